// >>> hdl/panel_pkg.sv
// shared constants and carrier types for the front-panel indicator block
package panel_pkg;
	localparam int ADC_CHANNELS      = 3;
	localparam int BLINK_TIME_MS     = 250;
	localparam int CLK_FREQ_HZ       = 40000000;
	localparam int BLINK_HALF_CYCLES = (CLK_FREQ_HZ / 1000) * BLINK_TIME_MS;
	localparam int SYNC_STAGES       = 2;
	localparam logic LED_DARK        = 1'h0;

	// status conditions gathered from the rest of the board
	typedef struct packed {
		logic                    link_up;
		logic                    user_ctl;
		logic                    timing_master;
		logic                    pps_valid;
		logic                    pps_pulse;
		logic [3:0]              sensor_alarm;
		logic                    sample_clk_valid;
		logic                    dac_fifo_empty;
		logic [ADC_CHANNELS-1:0] adc_overrange;
		logic [ADC_CHANNELS-1:0] adc_fifo_overrun;
	} panel_status_t;

	localparam int STATUS_W = $bits(panel_status_t);

	// the ten front-panel lamps
	typedef struct packed {
		logic                    link_indicator;
		logic                    user_indicator;
		logic                    timing_master_indicator;
		logic                    pps_indicator;
		logic                    thermal_alarm_indicator;
		logic                    clock_indicator;
		logic                    dac_empty_indicator;
		logic [ADC_CHANNELS-1:0] adc_overload_indicator;
	} panel_leds_t;
endpackage : panel_pkg

// >>> hdl/status_sync.sv
// two-flop synchroniser bank for asynchronous status levels
`timescale 1ns/100ps
module status_sync
	import panel_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// clock and reset
	input  wire logic             clk_sys_in,
	input  wire logic             rst_in,
	// levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] stable_r;

	// first stage feeds only the second stage
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			meta_r   <= '0;
			stable_r <= '0;
		end else begin
			meta_r   <= async_in;
			stable_r <= meta_r;
		end
	end

	assign sync_out = stable_r;
endmodule : status_sync

// >>> hdl/front_panel_status_leds.sv
// front-panel status indicator logic
// How it works
// RL1 - link lamp blinks while link is up, dark without link
// RL2 - user lamp follows only the user application control
// RL3 - master lamp lit in timing-bus master mode, dark as slave
// RL4 - software puts a lone module in master mode; slave needs external timing
// RL5 - pulse-per-second lamp on only when valid, toggles on each pulse
// RL6 - thermal lamp is OR of all sensor alarms
// RL7 - clock lamp lit while a valid sample clock is seen
// RL8 - clock-valid also gates acquisition data flow
// RL9 - D/A empty lamp lit while converter FIFO is empty
// RL10 - one overload lamp per A/D channel, own status only
// RL11 - overload lamp is overrange OR FIFO overrun of that channel
// RL12 - status inputs synchronised, acquisition data valid is not; lamps registered and dark in reset
`timescale 1ns/100ps
module front_panel_status_leds
	import panel_pkg::*;
#(
	parameter int BLINK_HALF = BLINK_HALF_CYCLES
) (
	// clock and reset
	input  wire logic          clk_sys_in,
	input  wire logic          rst_in,
	// status from other board units
	input  wire panel_status_t status_in,
	// acquisition data gate
	input  wire logic          acq_valid_in,
	output logic               acq_valid_out,
	// lamps
	output panel_leds_t        leds_out
);
	panel_status_t sts;
	panel_leds_t   leds_r;
	panel_leds_t   leds_nxt;
	logic [31:0]   blink_cnt_r;
	logic          blink_r;
	logic          pps_prev_r;
	logic          pps_lamp_r;
	logic          pps_lamp_nxt;
	logic          blink_wrap;
	logic          pps_rise;
	logic [ADC_CHANNELS-1:0] overload;
	logic [31:0]   link_hold_r;
	logic [31:0]   link_hold_nxt;
	logic          link_seen_r;

	// RL12 synchronise status
	status_sync #(
		.WIDTH(STATUS_W)
	) u_sync (
		.clk_sys_in(clk_sys_in),
		.rst_in    (rst_in),
		.async_in  (status_in),
		.sync_out  (sts)
	);

	assign blink_wrap = (blink_cnt_r == 32'(BLINK_HALF - 1));
	assign pps_rise   = sts.pps_pulse && !pps_prev_r;

	// RL1 link blink timer, runs only with link up
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			blink_cnt_r <= '0;
			blink_r     <= LED_DARK;
		end else if (!sts.link_up) begin
			blink_cnt_r <= '0;
			blink_r     <= LED_DARK;
		end else if (blink_wrap) begin
			blink_cnt_r <= '0;
			blink_r     <= !blink_r;
		end else begin
			blink_cnt_r <= blink_cnt_r + 32'h1;
		end
	end

	// RL5 toggle on each pulse while valid
	assign pps_lamp_nxt = !sts.pps_valid ? LED_DARK : (pps_rise ? !pps_lamp_r : pps_lamp_r);

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			pps_prev_r <= 1'h0;
			pps_lamp_r <= LED_DARK;
		end else begin
			pps_prev_r <= sts.pps_pulse;
			pps_lamp_r <= pps_lamp_nxt;
		end
	end

	// RL10 RL11 per-channel overload
	genvar ch;
	generate
		for (ch = 0; ch < ADC_CHANNELS; ch++) begin : g_ovl
			assign overload[ch] = sts.adc_overrange[ch] | sts.adc_fifo_overrun[ch];

			property p_ovl_own;
				@(posedge clk_sys_in) disable iff (rst_in)
				!(sts.adc_overrange[ch] | sts.adc_fifo_overrun[ch]) |=> !leds_out.adc_overload_indicator[ch];
			endproperty
			a_ovl_own: assert property (p_ovl_own) else $error("overload lamp lit by another channel"); // RL10
		end
	endgenerate

	always_comb begin
		// RL1 link lamp
		leds_nxt.link_indicator          = sts.link_up & blink_r;
		// RL2 user only
		leds_nxt.user_indicator          = sts.user_ctl;
		// RL3 master mode
		leds_nxt.timing_master_indicator = sts.timing_master;
		leds_nxt.pps_indicator           = pps_lamp_nxt;
		// RL6 any sensor
		leds_nxt.thermal_alarm_indicator = |sts.sensor_alarm;
		// RL7 clock present
		leds_nxt.clock_indicator         = sts.sample_clk_valid;
		// RL9 fifo empty
		leds_nxt.dac_empty_indicator     = sts.dac_fifo_empty;
		leds_nxt.adc_overload_indicator  = overload;
	end

	// RL12 registered lamps, dark in reset
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			leds_r <= '0;
		end else begin
			leds_r <= leds_nxt;
		end
	end

	assign leds_out = leds_r;

	// RL8 gate data without a clock; data valid is taken as already in this domain
	assign acq_valid_out = acq_valid_in & sts.sample_clk_valid;

	// RL1 still-lamp counter, checking only; a stuck lamp shows up here
	assign link_hold_nxt = (!sts.link_up || (leds_out.link_indicator != link_seen_r)) ? 32'h0 : link_hold_r + 32'h1;

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			link_hold_r <= '0;
			link_seen_r <= LED_DARK;
		end else begin
			link_hold_r <= link_hold_nxt;
			link_seen_r <= leds_out.link_indicator;
		end
	end

	// first dark phase waits one extra edge for the lamp register
	property p_link_blink;
		@(posedge clk_sys_in) disable iff (rst_in)
		link_hold_r <= 32'(BLINK_HALF + 1);
	endproperty
	a_link_blink: assert property (p_link_blink) else $error("link lamp stopped blinking"); // RL1

	property p_link_dark;
		@(posedge clk_sys_in) disable iff (rst_in)
		!sts.link_up |=> !leds_out.link_indicator;
	endproperty
	a_link_dark: assert property (p_link_dark) else $error("link lamp lit without link"); // RL1

	property p_user;
		@(posedge clk_sys_in) disable iff (rst_in)
		##1 leds_out.user_indicator == $past(sts.user_ctl);
	endproperty
	a_user: assert property (p_user) else $error("user lamp mismatch"); // RL2

	property p_master;
		@(posedge clk_sys_in) disable iff (rst_in)
		sts.timing_master |=> leds_out.timing_master_indicator;
	endproperty
	a_master: assert property (p_master) else $error("master lamp not lit"); // RL3

	property p_master_dark;
		@(posedge clk_sys_in) disable iff (rst_in)
		!sts.timing_master |=> !leds_out.timing_master_indicator;
	endproperty
	a_master_dark: assert property (p_master_dark) else $error("master lamp lit as slave"); // RL3

	property p_pps;
		@(posedge clk_sys_in) disable iff (rst_in)
		(sts.pps_valid && pps_rise) |=> (leds_out.pps_indicator != $past(pps_lamp_r));
	endproperty
	a_pps: assert property (p_pps) else $error("pps lamp did not toggle"); // RL5

	property p_pps_dark;
		@(posedge clk_sys_in) disable iff (rst_in)
		!sts.pps_valid |=> !leds_out.pps_indicator;
	endproperty
	a_pps_dark: assert property (p_pps_dark) else $error("pps lamp lit while invalid"); // RL5

	property p_thermal;
		@(posedge clk_sys_in) disable iff (rst_in)
		(|sts.sensor_alarm) |=> leds_out.thermal_alarm_indicator;
	endproperty
	a_thermal: assert property (p_thermal) else $error("thermal lamp missed alarm"); // RL6

	property p_thermal_dark;
		@(posedge clk_sys_in) disable iff (rst_in)
		!(|sts.sensor_alarm) |=> !leds_out.thermal_alarm_indicator;
	endproperty
	a_thermal_dark: assert property (p_thermal_dark) else $error("thermal lamp lit without alarm"); // RL6

	property p_clock;
		@(posedge clk_sys_in) disable iff (rst_in)
		##1 leds_out.clock_indicator == $past(sts.sample_clk_valid);
	endproperty
	a_clock: assert property (p_clock) else $error("clock lamp mismatch"); // RL7

	property p_gate;
		@(posedge clk_sys_in) disable iff (rst_in)
		!sts.sample_clk_valid |-> !acq_valid_out;
	endproperty
	a_gate: assert property (p_gate) else $error("data passed without clock"); // RL8

	property p_dac;
		@(posedge clk_sys_in) disable iff (rst_in)
		sts.dac_fifo_empty |=> leds_out.dac_empty_indicator;
	endproperty
	a_dac: assert property (p_dac) else $error("empty lamp not lit"); // RL9

	property p_dac_dark;
		@(posedge clk_sys_in) disable iff (rst_in)
		!sts.dac_fifo_empty |=> !leds_out.dac_empty_indicator;
	endproperty
	a_dac_dark: assert property (p_dac_dark) else $error("empty lamp lit with data"); // RL9

	property p_ovl;
		@(posedge clk_sys_in) disable iff (rst_in)
		##1 leds_out.adc_overload_indicator == $past(sts.adc_overrange | sts.adc_fifo_overrun);
	endproperty
	a_ovl: assert property (p_ovl) else $error("overload lamps mismatch"); // RL11

	property p_reset_dark;
		@(posedge clk_sys_in) rst_in |=> (leds_out == '0) || rst_in;
	endproperty
	a_reset_dark: assert property (p_reset_dark) else $error("lamp lit after reset"); // RL12
endmodule : front_panel_status_leds

// >>> verif/panel_viewer.sv
// operator view of the lamps, timing the link lamp blink
`timescale 1ns/100ps
module panel_viewer
	import panel_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	// lamps and blink figures
	input  wire panel_leds_t leds_in,
	output int               flips_out,
	output int               min_run_out
);
	int   run;
	logic last;
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			flips_out <= 0;
			min_run_out <= 1000;
			run <= 0;
			last <= 1'h0;
		end else begin
			last <= leds_in.link_indicator;
			run <= (leds_in.link_indicator != last) ? 1 : run + 1;
			if (leds_in.link_indicator != last) begin
				flips_out <= flips_out + 1;
				// first dark stretch is not a blink period
				if (flips_out > 0 && run < min_run_out)
					min_run_out <= run;
			end
		end
	end
endmodule : panel_viewer

// >>> verif/front_panel_status_leds_bench.sv
// self-checking bench for the front-panel indicator block
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; $display("unexpected t=%0t %h %h", $time, a, b); end end
module front_panel_status_leds_bench;
	import panel_pkg::*;
	localparam panel_leds_t ALL_DARK = '0;
	logic          clk_sys_in = 1'h0;
	logic          rst_in     = 1'h1;
	panel_status_t st         = '0;
	logic          acq_in     = 1'h0;
	logic          acq_out;
	panel_leds_t   leds;
	panel_status_t v;
	logic          a;
	logic          ep;
	int            n_errors   = 0;
	int            checks     = 0;
	int            flips;
	int            min_run;
	always #12.5 clk_sys_in = ~clk_sys_in;
	// short blink so the run stays brief
	front_panel_status_leds #(.BLINK_HALF(4)) dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .status_in(st),
		.acq_valid_in(acq_in), .acq_valid_out(acq_out), .leds_out(leds));
	panel_viewer viewer (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .leds_in(leds), .flips_out(flips),
		.min_run_out(min_run));
	function automatic panel_leds_t expect_leds(panel_status_t s);
		panel_leds_t e;
		e = '0;
		e.user_indicator = s.user_ctl;
		e.timing_master_indicator = s.timing_master;
		e.thermal_alarm_indicator = |s.sensor_alarm;
		e.clock_indicator = s.sample_clk_valid;
		e.dac_empty_indicator = s.dac_fifo_empty;
		e.adc_overload_indicator = s.adc_overrange | s.adc_fifo_overrun;
		return e;
	endfunction : expect_leds
	// two sync stages plus the lamp register, then one spare edge
	task automatic settle(input panel_status_t s, input logic acq);
		@(posedge clk_sys_in);
		st <= s;
		acq_in <= acq;
		repeat (4) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
	endtask : settle
	task automatic report_and_stop;
		if (n_errors == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop
	initial begin
		void'($urandom(32'h6f103a89));
		repeat (6) @(posedge clk_sys_in);
		rst_in <= 1'h0;
		for (int i = 0; i < 40; i++) begin
			v = (i == 0) ? '1 : (i == 1) ? '0 : panel_status_t'(STATUS_W'($urandom));
			v.link_up = 1'h0;
			v.pps_valid = 1'h0;
			v.pps_pulse = 1'h0;
			a = 1'($urandom);
			settle(v, a);
			`CHK(leds, expect_leds(v))
			`CHK(acq_out, a & v.sample_clk_valid)
		end
		v.pps_pulse = 1'h1;
		settle(v, 1'h0);
		`CHK(leds.pps_indicator, 1'h0)
		ep = 1'h0;
		v.pps_pulse = 1'h0;
		v.pps_valid = 1'h1;
		for (int i = 0; i < 6; i++) begin
			settle(v, 1'h0);
			`CHK(leds.pps_indicator, ep)
			v.pps_pulse = ~v.pps_pulse;
			ep = ep ^ v.pps_pulse;
		end
		v.user_ctl = 1'h1;
		settle(v, 1'h1);
		`CHK(leds.user_indicator, 1'h1)
		@(posedge clk_sys_in);
		rst_in <= 1'h1;
		@(negedge clk_sys_in);
		`CHK(leds, ALL_DARK)
		repeat (2) @(posedge clk_sys_in);
		rst_in <= 1'h0;
		@(negedge clk_sys_in);
		`CHK(leds, ALL_DARK)
		@(negedge clk_sys_in);
		`CHK(leds, ALL_DARK)
		v = '0;
		v.link_up = 1'h1;
		v.timing_master = 1'h1;
		settle(v, 1'h0);
		repeat (40) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		`CHK(flips >= 8 && flips <= 12, 1'h1)
		`CHK(min_run, 4)
		`CHK(leds.timing_master_indicator, 1'h1)
		v.link_up = 1'h0;
		settle(v, 1'h0);
		repeat (8) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		`CHK(leds.link_indicator, 1'h0)
		report_and_stop();
	end
endmodule : front_panel_status_leds_bench
